// ==== logic/timer_consts.svh ====
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// register bus geometry
`define TMR_ADDR_W 4
`define TMR_DATA_W 16

// register offsets
`define OFF_MODE_CTRL 4'h0
`define OFF_CAPCOMP_CTRL 4'h1
`define OFF_PRESCALER_CTRL 4'h2
`define OFF_UP_COUNTER 4'h3
`define OFF_FIRST_CAPCOMP 4'h4
`define OFF_SECOND_CAPCOMP 4'h5
`define OFF_IRQ_STATUS 4'h6
`define OFF_IRQ_CLEAR 4'h7
`define OFF_IRQ_ENABLE 4'h8

// timer_mode_ctrl fields
`define MODE_HI_BIT 3
`define MODE_LO_BIT 2
`define TOGGLE_CLR_BIT 1
`define MODE_CTRL_W 4

// capcomp_ctrl fields
`define CC_CAP0_BIT 0
`define CC_REV_BIT 1
`define CC_CAP1_BIT 2
`define CAPCOMP_CTRL_W 3

// prescaler_mode_ctrl fields
`define PRM_CLK_HI 1
`define PRM_CLK_LO 0
`define PRM_PEDGE_HI 5
`define PRM_PEDGE_LO 4
`define PRM_SEDGE_HI 7
`define PRM_SEDGE_LO 6
`define PRESCALER_CTRL_W 8

// operating mode codes
`define MODE_STOP 2'h0
`define MODE_CLEAR_START 2'h2

// edge select codes
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3

// count clock select codes
`define CLK_DIV1 2'h0
`define CLK_DIV2 2'h1
`define CLK_DIV16 2'h2
`define CLK_PRIMARY 2'h3

// prescaler tap masks
`define PRESCALE_W 8
`define PRE_MASK_DIV2 8'h01
`define PRE_MASK_DIV16 8'h0F

// interrupt status bits
`define IRQ_W 2
`define IRQ_FIRST_BIT 0
`define IRQ_SECOND_BIT 1

// counter reset value and maximum
`define COUNTER_RESET 16'h0000
`define COUNTER_MAX 16'hFFFF

`endif

// ==== logic/timer_pkg.sv ====
`include "timer_consts.svh"

package timer_pkg;

  typedef struct packed {
    logic [`TMR_ADDR_W-1:0] address;
    logic [`TMR_DATA_W-1:0] write_data;
    logic write_strobe;
    logic read_strobe;
  } reg_bus_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
  } edge_state_type;

  typedef struct packed {
    logic [`MODE_CTRL_W-1:0] mode_ctrl;
    logic [`CAPCOMP_CTRL_W-1:0] capcomp_ctrl;
    logic [`PRESCALER_CTRL_W-1:0] prescaler_ctrl;
    logic [`TMR_DATA_W-1:0] up_counter;
    logic [`TMR_DATA_W-1:0] first_capcomp_reg;
    logic [`TMR_DATA_W-1:0] second_capcomp_reg;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_enable;
    logic [`PRESCALE_W-1:0] prescale;
    logic fresh;
    logic timer_output;
    logic first_irq;
    logic second_irq;
    logic irq;
    logic [`TMR_DATA_W-1:0] read_data;
  } timer_state_type;

endpackage : timer_pkg

// ==== logic/trigger_edge_detect.sv ====
`timescale 1ns/1ps
`include "timer_consts.svh"

module trigger_edge_detect
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  edge_state_type st;
  edge_state_type next_st;

  // two-stage synchroniser, then a history flop for edge detection
  always_comb begin
    next_st = st;
    next_st.sync1 = pin;
    next_st.sync2 = st.sync1;
    next_st.last = st.sync2;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // only the second stage and its history are looked at
  assign rise = st.sync2 & ~st.last;
  assign fall = ~st.sync2 & st.last;

endmodule : trigger_edge_detect

// ==== logic/timer_edge_clear_capture.sv ====
// Functional notes
// - mode code 10 starts clear-and-start counting up from zero
// - without a clearing edge the counter wraps past maximum and keeps counting
// - output toggles on match, and also on primary edge when toggle bit set
// - second register capture: primary edge loads it, raises second irq, clears counter
// - compare value zero matches right after a clear
// - match when counter equals compare value; value three gives four clocks
// - reverse-phase capture: clear on valid edge, load first register on opposite edge
// - reverse-phase capture of first register raises no first irq
// - in reverse-phase capture, secondary edge raises first irq without capture
// - both-edge detection: each edge captures, clears and toggles
// - with both registers capturing, no primary edge means output stays low
// - counter read returns count without disturbing it
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "timer_consts.svh"

module timer_edge_clear_capture
  import timer_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire reg_bus_type bus,
  output logic [`TMR_DATA_W-1:0] read_data,
  input wire logic primary_trigger_input,
  input wire logic secondary_trigger_input,
  output logic timer_output_pin,
  output logic first_event_irq,
  output logic second_event_irq,
  output logic irq
);

  timer_state_type st;
  timer_state_type next_st;

  logic prim_rise;
  logic prim_fall;
  logic sec_rise;
  logic sec_fall;

  // synchronised edge detectors for both trigger pins
  trigger_edge_detect primary_detect (
    .clock(clock),
    .resetn(resetn),
    .pin(primary_trigger_input),
    .rise(prim_rise),
    .fall(prim_fall)
  );

  trigger_edge_detect secondary_detect (
    .clock(clock),
    .resetn(resetn),
    .pin(secondary_trigger_input),
    .rise(sec_rise),
    .fall(sec_fall)
  );

  // valid edge per two-bit select; code 10 selects nothing
  function automatic logic valid_edge(input logic [1:0] sel, input logic r, input logic f);
    logic v;
    v = 1'b0;
    case (sel)
      `EDGE_FALL: v = f;
      `EDGE_RISE: v = r;
      `EDGE_BOTH: v = r | f;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : valid_edge

  // phase opposite to the valid edge; both-edge selection stays both
  function automatic logic opposite_edge(input logic [1:0] sel, input logic r, input logic f);
    logic v;
    v = 1'b0;
    case (sel)
      `EDGE_FALL: v = r;
      `EDGE_RISE: v = f;
      `EDGE_BOTH: v = r | f;
      default: v = 1'b0;
    endcase
    return v;
  endfunction : opposite_edge

  // decoded controls
  logic [1:0] op_mode;
  logic toggle_on_clear_bit;
  logic cap0;
  logic cap1;
  logic reverse_phase_capture_sel;
  logic [1:0] clk_sel;
  logic running;
  logic clear_start;
  logic tick;
  logic prim_valid;
  logic prim_opp;
  logic sec_valid;
  logic clr_edge;
  logic hold_cleared;
  logic match0;
  logic match1;
  logic toggle;
  logic ev_first;
  logic ev_second;

  assign op_mode = st.mode_ctrl[`MODE_HI_BIT:`MODE_LO_BIT];
  assign toggle_on_clear_bit = st.mode_ctrl[`TOGGLE_CLR_BIT];
  assign cap0 = st.capcomp_ctrl[`CC_CAP0_BIT];
  assign cap1 = st.capcomp_ctrl[`CC_CAP1_BIT];
  assign reverse_phase_capture_sel = st.capcomp_ctrl[`CC_REV_BIT];
  assign clk_sel = st.prescaler_ctrl[`PRM_CLK_HI:`PRM_CLK_LO];
  assign running = (op_mode != `MODE_STOP);
  assign clear_start = (op_mode == `MODE_CLEAR_START);

  // count clock: prescaler taps, or the primary valid edge
  always_comb begin
    case (clk_sel)
      `CLK_DIV1: tick = 1'b1;
      `CLK_DIV2: tick = (st.prescale & `PRE_MASK_DIV2) == `PRE_MASK_DIV2;
      `CLK_DIV16: tick = (st.prescale & `PRE_MASK_DIV16) == `PRE_MASK_DIV16;
      default: tick = prim_valid;
    endcase
  end

  // edge qualification
  assign prim_valid = valid_edge(st.prescaler_ctrl[`PRM_PEDGE_HI:`PRM_PEDGE_LO], prim_rise, prim_fall);
  assign prim_opp = opposite_edge(st.prescaler_ctrl[`PRM_PEDGE_HI:`PRM_PEDGE_LO], prim_rise, prim_fall);
  assign sec_valid = valid_edge(st.prescaler_ctrl[`PRM_SEDGE_HI:`PRM_SEDGE_LO], sec_rise, sec_fall);
  assign clr_edge = clear_start & prim_valid;
  // primary edge as count clock in clear-start mode pins the counter at zero
  assign hold_cleared = clear_start & (clk_sel == `CLK_PRIMARY);

  // compare only against a value the counter has just taken, so one match per value
  // zero matches right after a clear
  assign match0 = running & ~cap0 & st.fresh & (st.up_counter == st.first_capcomp_reg);
  assign match1 = running & ~cap1 & st.fresh & (st.up_counter == st.second_capcomp_reg);

  // match toggles, primary edge toggles when enabled
  // an OR of the causes, so a coincident clear and match toggle once
  assign toggle = match0 | match1 | (toggle_on_clear_bit & clr_edge);

  // secondary edge always reports when first register captures
  assign ev_first = match0 | (running & cap0 & sec_valid);
  // capture on primary edge reports on the second line
  assign ev_second = match1 | (cap1 & clr_edge);

  // next-state computation
  always_comb begin
    next_st = st;
    next_st.prescale = st.prescale + `PRESCALE_W'(1);
    next_st.fresh = 1'b0;
    next_st.read_data = '0;

    // software writes; hardware captures below take priority over them
    if (bus.write_strobe) begin
      case (bus.address)
        `OFF_MODE_CTRL: next_st.mode_ctrl = bus.write_data[`MODE_CTRL_W-1:0];
        `OFF_CAPCOMP_CTRL: next_st.capcomp_ctrl = bus.write_data[`CAPCOMP_CTRL_W-1:0];
        `OFF_PRESCALER_CTRL: next_st.prescaler_ctrl = bus.write_data[`PRESCALER_CTRL_W-1:0];
        `OFF_FIRST_CAPCOMP: next_st.first_capcomp_reg = bus.write_data;
        `OFF_SECOND_CAPCOMP: next_st.second_capcomp_reg = bus.write_data;
        `OFF_IRQ_ENABLE: next_st.irq_enable = bus.write_data[`IRQ_W-1:0];
        default: next_st.mode_ctrl = st.mode_ctrl;
      endcase
    end

    // counter
    if (!running) begin
      // stopped counter sits at zero so the mode starts from zero
      next_st.up_counter = `COUNTER_RESET;
    end else if (clr_edge) begin
      // clear to zero on the valid edge
      next_st.up_counter = `COUNTER_RESET;
      next_st.fresh = 1'b1;
    end else if (hold_cleared) begin
      next_st.up_counter = `COUNTER_RESET;
    end else if (tick) begin
      next_st.up_counter = st.up_counter + `TMR_DATA_W'(1);
      next_st.fresh = 1'b1;
    end

    // second register captures the pre-clear count
    if (cap1 && clr_edge) begin
      next_st.second_capcomp_reg = st.up_counter;
    end

    // first register capture source
    if (running && cap0) begin
      if (reverse_phase_capture_sel) begin
        // opposite phase loads the first register
        if (prim_opp) begin
          next_st.first_capcomp_reg = st.up_counter;
        end
      end else if (sec_valid) begin
        next_st.first_capcomp_reg = st.up_counter;
      end
    end

    // stopped output rests low; it only moves on a toggle cause
    if (!running) begin
      next_st.timer_output = 1'b0;
    end else begin
      next_st.timer_output = st.timer_output ^ toggle;
    end

    next_st.first_irq = ev_first;
    next_st.second_irq = ev_second;

    // sticky status: a set in the clearing cycle wins
    if (bus.write_strobe && bus.address == `OFF_IRQ_CLEAR) begin
      next_st.irq_status = st.irq_status & ~bus.write_data[`IRQ_W-1:0];
    end
    next_st.irq_status[`IRQ_FIRST_BIT] = next_st.irq_status[`IRQ_FIRST_BIT] | ev_first;
    next_st.irq_status[`IRQ_SECOND_BIT] = next_st.irq_status[`IRQ_SECOND_BIT] | ev_second;
    next_st.irq = |(next_st.irq_status & next_st.irq_enable);

    // read port: data stands one cycle after the strobe, unmapped reads zero
    if (bus.read_strobe) begin
      case (bus.address)
        `OFF_MODE_CTRL: next_st.read_data = {{(`TMR_DATA_W-`MODE_CTRL_W){1'b0}}, st.mode_ctrl};
        `OFF_CAPCOMP_CTRL: next_st.read_data = {{(`TMR_DATA_W-`CAPCOMP_CTRL_W){1'b0}}, st.capcomp_ctrl};
        `OFF_PRESCALER_CTRL: next_st.read_data = {{(`TMR_DATA_W-`PRESCALER_CTRL_W){1'b0}}, st.prescaler_ctrl};
        // plain read of the live count, no side effect
        `OFF_UP_COUNTER: next_st.read_data = st.up_counter;
        `OFF_FIRST_CAPCOMP: next_st.read_data = st.first_capcomp_reg;
        `OFF_SECOND_CAPCOMP: next_st.read_data = st.second_capcomp_reg;
        `OFF_IRQ_STATUS: next_st.read_data = {{(`TMR_DATA_W-`IRQ_W){1'b0}}, st.irq_status};
        `OFF_IRQ_ENABLE: next_st.read_data = {{(`TMR_DATA_W-`IRQ_W){1'b0}}, st.irq_enable};
        default: next_st.read_data = '0;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign read_data = st.read_data;
  assign timer_output_pin = st.timer_output;
  assign first_event_irq = st.first_irq;
  assign second_event_irq = st.second_irq;
  assign irq = st.irq;

  // checks on the running and stopped timer
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_enter_mode_zero: assert property (
    (!running && !bus.write_strobe) |=> st.up_counter == `COUNTER_RESET)
    else $error("counter not zero while stopped");

  a_wrap_continue: assert property (
    (running && !clr_edge && !hold_cleared && tick && st.up_counter == `COUNTER_MAX)
      |=> (st.up_counter == `COUNTER_RESET && st.fresh))
    else $error("counter did not wrap past maximum");

  a_capture_clear: assert property (
    (cap1 && clr_edge) |=> (st.second_capcomp_reg == $past(st.up_counter)
      && st.up_counter == `COUNTER_RESET ##0 second_event_irq))
    else $error("second capture or clear missing");

  a_zero_match: assert property (
    (clr_edge && !cap0 && st.first_capcomp_reg == `COUNTER_RESET && !bus.write_strobe)
      |=> ##1 first_event_irq)
    else $error("zero compare missed after clear");

  a_match_value: assert property (
    (first_event_irq && !$past(cap0)) |-> $past(st.up_counter, 1) == $past(st.first_capcomp_reg, 1))
    else $error("first irq without equal compare");

  a_reverse_silent: assert property (
    (running && cap0 && reverse_phase_capture_sel && prim_opp && !sec_valid && !match0)
      |=> (!first_event_irq && st.first_capcomp_reg == $past(st.up_counter)))
    else $error("reverse capture wrong");

  a_secondary_irq: assert property (
    (running && cap0 && reverse_phase_capture_sel && sec_valid && !prim_opp && !bus.write_strobe)
      |=> (first_event_irq && $stable(st.first_capcomp_reg)))
    else $error("secondary edge handling wrong");

  a_both_edges: assert property (
    (clear_start && st.prescaler_ctrl[`PRM_PEDGE_HI:`PRM_PEDGE_LO] == `EDGE_BOTH
      && (prim_rise || prim_fall)) |=> st.up_counter == `COUNTER_RESET)
    else $error("both-edge clear missing");

  a_output_steady: assert property (
    (running && !toggle && !bus.write_strobe) |=> $stable(timer_output_pin))
    else $error("output moved without a cause");

  a_toggle_once: assert property (
    (running && toggle && !bus.write_strobe) |=> timer_output_pin != $past(timer_output_pin))
    else $error("output did not toggle exactly once");

  a_counter_read: assert property (
    (bus.read_strobe && bus.address == `OFF_UP_COUNTER) |=> read_data == $past(st.up_counter))
    else $error("counter read mismatch");

  a_count_step: assert property (
    (running && tick && !clr_edge && !hold_cleared && !bus.write_strobe)
      |=> st.up_counter == $past(st.up_counter) + `TMR_DATA_W'(1))
    else $error("counter step wrong");

  c_zero_match: cover property (clr_edge ##2 first_event_irq);
  c_second_capture: cover property (cap1 && clr_edge);
  c_reverse_capture: cover property (cap0 && reverse_phase_capture_sel && prim_opp);
  c_secondary_irq: cover property (cap0 && sec_valid ##1 first_event_irq);

endmodule : timer_edge_clear_capture

// ==== testbench/trigger_source.sv ====
`timescale 1ns/1ps
// far side: the pulse sources on the two trigger pins
module trigger_source (
  input wire logic clock,
  output logic primary,
  output logic secondary
);
  initial begin
    primary = 1'b0;
    secondary = 1'b0;
  end

  // levels move right after an edge; at least two clocks each, or the synchroniser misses them
  task automatic drive(input logic p, input logic s, input int n);
    primary <= p;
    secondary <= s;
    repeat ((n < 2) ? 2 : n) @(posedge clock);
  endtask : drive
endmodule : trigger_source

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "timer_consts.svh"
module tb
  import timer_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  reg_bus_type bus = '0;
  logic [15:0] read_data;
  logic primary, secondary, pin, first_irq, second_irq, irq;
  logic last1 = 1'b0, last2 = 1'b0, lastp = 1'b0;
  logic [15:0] rv, c;
  logic [31:0] seed = 32'h0000001C;
  int n_fail = 0;
  int n_checks = 0;
  int np1 = 0, nh1 = 0, np2 = 0, nh2 = 0, ntog = 0, run = 0, width = 0;
  int b1, b2, bt, n, h1, h2;

  always #25 clock = ~clock;

  timer_edge_clear_capture uut (
    .clock(clock), .resetn(resetn), .bus(bus), .read_data(read_data),
    .primary_trigger_input(primary), .secondary_trigger_input(secondary),
    .timer_output_pin(pin), .first_event_irq(first_irq),
    .second_event_irq(second_irq), .irq(irq));

  trigger_source src (.clock(clock), .primary(primary), .secondary(secondary));

  // bench model state: pulse counts, high cycles, output toggles and run length
  always @(posedge clock) begin
    np1 <= np1 + (first_irq & ~last1);
    nh1 <= nh1 + first_irq;
    np2 <= np2 + (second_irq & ~last2);
    nh2 <= nh2 + second_irq;
    ntog <= ntog + (pin ^ lastp);
    run <= (pin ^ lastp) ? 1 : run + 1;
    if (pin ^ lastp) width <= run;
    last1 <= first_irq;
    last2 <= second_irq;
    lastp <= pin;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // xorshift from a fixed seed, so pin spacings repeat from run to run and change only with the seed
  function automatic int rnd(input int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 3 + seed % span;
  endfunction : rnd

  // one bus cycle plus an idle cycle, so no strobe is assigned twice in a step
  task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d);
    bus <= '{a, d, w, ~w};
    @(posedge clock);
    #1 rv = read_data;
    bus <= '0;
    @(posedge clock);
    #1;
  endtask : op

  task automatic settle;
    repeat (8) @(posedge clock);
    #1;
  endtask : settle

  task automatic base;
    b1 = np1;
    b2 = np2;
    bt = ntog;
  endtask : base

  // count clock stays off the primary edge
  task automatic cfg(input logic [3:0] m, input logic [2:0] cc, input logic [7:0] pre,
                     input logic [15:0] c0, input logic [15:0] c1, input logic [1:0] en);
    op(1, `OFF_MODE_CTRL, 16'h0000);
    op(1, `OFF_CAPCOMP_CTRL, cc);
    op(1, `OFF_PRESCALER_CTRL, pre);
    op(1, `OFF_FIRST_CAPCOMP, c0);
    op(1, `OFF_SECOND_CAPCOMP, c1);
    op(1, `OFF_IRQ_ENABLE, en);
    op(1, `OFF_IRQ_CLEAR, 16'h0003);
    op(1, `OFF_MODE_CTRL, m);
    settle();
    base();
  endtask : cfg

  // event counts since the last baseline
  task automatic ev(input int e1, input int e2, input int et);
    settle();
    check("first irq", np1 - b1, e1);
    check("second irq", np2 - b2, e2);
    check("toggles", ntog - bt, et);
  endtask : ev

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    // read-only and unmapped writes are dropped
    op(1, `OFF_UP_COUNTER, 16'hFFFF);
    op(1, `OFF_IRQ_STATUS, 16'hFFFF);
    op(1, 4'h9, 16'hFFFF);
    for (int a = 0; a < 10; a++) begin
      op(0, a[3:0], 16'h0000);
      check("reset value", rv, 0);
    end
    // second register captures, compare at zero, toggle on clear
    cfg(4'hA, 3'h4, 8'h10, 16'h0000, 16'h1234, 2'h2);
    n = rnd(40) + 3;
    src.drive(1, 0, 3);
    src.drive(0, 0, n - 3);
    src.drive(1, 0, 3);
    src.drive(0, 0, 2);
    ev(2, 2, 4);
    check("zero match width", width, 1);
    op(0, `OFF_SECOND_CAPCOMP, 16'h0000);
    check("capture", rv, n - 1);
    check("irq level", irq, 1);
    op(0, `OFF_IRQ_STATUS, 16'h0000);
    check("status", rv, 3);
    op(1, `OFF_IRQ_CLEAR, 16'h0002);
    check("irq cleared", irq, 0);
    op(1, `OFF_IRQ_ENABLE, 16'h0001);
    check("irq unmasked", irq, 1);
    op(1, `OFF_IRQ_CLEAR, 16'h0001);
    check("irq cleared", irq, 0);
    op(0, `OFF_UP_COUNTER, 16'h0000);
    c = rv;
    n = rnd(200);
    repeat (n) @(posedge clock);
    op(0, `OFF_UP_COUNTER, 16'h0000);
    check("count step", rv - c, n + 2);
    // compare at three gives a four-clock pulse
    cfg(4'hA, 3'h4, 8'h10, 16'h0003, 16'hFFFF, 2'h0);
    src.drive(1, 0, 3);
    src.drive(0, 0, 8);
    ev(1, 1, 2);
    check("pulse width", width, 4);
    // toggle on clear off: match alone moves the output
    op(1, `OFF_MODE_CTRL, 16'h0008);
    settle();
    base();
    src.drive(1, 0, 3);
    src.drive(0, 0, 8);
    ev(1, 1, 1);
    base();
    op(0, `OFF_UP_COUNTER, 16'h0000);
    c = rv;
    repeat (65534) @(posedge clock);
    op(0, `OFF_UP_COUNTER, 16'h0000);
    check("wrap", rv, c);
    ev(1, 0, 1);
    // pulse measurement with the first interrupt masked
    src.drive(1, 0, 2);
    cfg(4'h8, 3'h7, 8'h40, 16'h0000, 16'h0000, 2'h2);
    h1 = rnd(30);
    h2 = rnd(30);
    src.drive(0, 0, h1);
    src.drive(1, 0, h2);
    src.drive(0, 0, 3);
    ev(0, 2, 0);
    // both captures read before any later edge
    op(0, `OFF_FIRST_CAPCOMP, 16'h0000);
    c = rv;
    check("low width", c, h1 - 1);
    op(0, `OFF_SECOND_CAPCOMP, 16'h0000);
    check("high width", rv - c, h2);
    op(1, `OFF_IRQ_CLEAR, 16'h0003);
    src.drive(0, 1, 3);
    src.drive(0, 0, 2);
    ev(1, 2, 0);
    check("masked irq", irq, 0);
    op(0, `OFF_FIRST_CAPCOMP, 16'h0000);
    check("no capture", rv, c);
    // both captures, both edges; no primary edge first
    cfg(4'hA, 3'h5, 8'hF0, 16'h0000, 16'h0000, 2'h0);
    src.drive(0, 1, 4);
    src.drive(0, 0, 4);
    ev(2, 0, 0);
    check("output low", pin, 0);
    n = rnd(30) + 3;
    src.drive(1, 0, n);
    src.drive(0, 0, 3);
    ev(2, 2, 2);
    op(0, `OFF_SECOND_CAPCOMP, 16'h0000);
    check("both edges", rv, n - 1);
    // free-running on the sixteen-cycle tap: 160 clocks give exactly ten steps
    cfg(4'h4, 3'h0, 8'h02, 16'hFFFF, 16'hFFFF, 2'h0);
    op(0, `OFF_UP_COUNTER, 16'h0000);
    c = rv;
    repeat (158) @(posedge clock);
    op(0, `OFF_UP_COUNTER, 16'h0000);
    check("div16 step", rv - c, 10);
    // primary edge as count clock in mode 10 keeps the counter at zero
    op(1, `OFF_PRESCALER_CTRL, 16'h0013);
    op(1, `OFF_MODE_CTRL, 16'h0008);
    settle();
    op(0, `OFF_UP_COUNTER, 16'h0000);
    check("held at zero", rv, 0);
    check("first pulses", nh1, np1);
    check("second pulses", nh2, np2);
    end_of_test();
  end

  // cut a hang short
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
endmodule : tb
